// ==== shared/port_link_defines.svh ====
// offsets, field positions, reset values and timing counts
`ifndef PORT_LINK_DEFINES_SVH
`define PORT_LINK_DEFINES_SVH
// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define NUM_PORTS     8
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_SEL       8'h00
`define OFS_CFG       8'h04
`define OFS_IRQ_STAT  8'h10
`define OFS_IRQ_CLR   8'h14
`define OFS_IRQ_EN    8'h18
`define OFS_PSTAT     8'h20
`define PSTAT_PAGE    3'h1
// ---------------------------------------------------------------
// config word fields
// ---------------------------------------------------------------
`define CFG_MODE_MSB  2
`define CFG_EN_BIT    3
`define CFG_FC_BIT    4
`define CFG_LB_BIT    5
// ---------------------------------------------------------------
// speed/duplex setting codes and speed codes
// ---------------------------------------------------------------
`define MODE_AUTO     3'h0
`define MODE_10F      3'h1
`define MODE_10H      3'h2
`define MODE_100F     3'h3
`define MODE_100H     3'h4
`define MODE_1000F    3'h5
`define SPD_10        2'h0
`define SPD_100       2'h1
`define SPD_1000      2'h2
// ability bits: 10h, 10f, 100h, 100f, 1000f
`define ABIL_ALL      5'h1F
`define ABIL_1000F    5'h10
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_MODE      3'h0
`define RST_EN        1'h1
`define RST_FC        1'h0
`define RST_LB        1'h0
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_MHZ       200
`define SETTLE_NS     1000
`define SETTLE_CYC    ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`endif

// ==== shared/port_link_pkg.sv ====
// types shared by the port link controller
`include "port_link_defines.svh"
package port_link_pkg;
   // -------------------------------------------------------------
   // link state machine
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      LS_DOWN   = 2'b00,
      LS_SETTLE = 2'b01,
      LS_UP     = 2'b10,
      LS_OFF    = 2'b11
   } link_state_type;
   // -------------------------------------------------------------
   // line side bundles
   // -------------------------------------------------------------
   typedef struct packed {
      logic       sig_detect;
      logic       peer_an;
      logic [4:0] peer_abil;
      logic [1:0] sensed_spd;
      logic       crossed;
      logic       buf_full;
      logic       rx_busy;
      logic       rx_valid;
      logic [7:0] rxd;
      logic       tx_valid;
      logic [7:0] txd;
   } line_in_type;
   typedef struct packed {
      logic       link_up;
      logic [1:0] speed;
      logic       full;
      logic       fc_on;
      logic       mdi_swap;
      logic       pause_send;
      logic       jam;
      logic       tx_ready;
      logic       tx_en;
      logic [7:0] txd;
      logic       rx_valid;
      logic [7:0] rxd;
   } line_out_type;
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [2:0]     mode;
      logic           en;
      logic           fc;
      logic           lb;
      link_state_type ls;
      logic [7:0]     cnt;
      logic           buf_q;
      line_out_type   o;
   } port_state_type;
   typedef struct packed {
      port_state_type [`NUM_PORTS-1:0] ports;
      logic [`NUM_PORTS-1:0]           sel;
      logic [`NUM_PORTS-1:0]           irq_stat;
      logic [`NUM_PORTS-1:0]           irq_en;
      logic                            wr_pend;
      logic [7:0]                      wr_addr;
      logic [31:0]                     rdata;
      logic                            irq;
   } state_type;
endpackage

// ==== tb/link_peer.sv ====
// link partner port model standing on the far side of one switch port
`timescale 1ns/1ps
module link_peer
(
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   // stimulus: plug, an, abil, spd, cross, buf full, talk
   input  wire logic [11:0]                 ctl,
   // mac transmit byte with valid on top
   input  wire logic [8:0]                  mac_tx,
   // switch port bundles
   input  wire port_link_pkg::line_out_type lo,
   output port_link_pkg::line_in_type       li
);
   logic [7:0] pat;

   // released receive line shows a byte that changes every cycle
   always_ff @(posedge ref_clk)
      pat <= sys_rst ? 8'h00 : pat + 8'h5B;

   // line levels seen by the switch port
   always_comb
   begin
      li = '0;
      li.sig_detect = ctl[0];
      li.peer_an = ctl[0] & ctl[1];
      li.peer_abil = ctl[6:2];
      li.sensed_spd = ctl[8:7];
      li.crossed = ctl[9];
      li.buf_full = ctl[10];
      li.rx_busy = ctl[0] & ctl[11] & !lo.tx_en;
      li.rx_valid = li.rx_busy; // bytes arrive while the peer talks
      li.rxd = pat;
      {li.tx_valid, li.txd} = mac_tx;
   end
endmodule // link_peer

// ==== tb/port_link_config_flow_control_tb.sv ====
// self-checking bench for the port link controller
`timescale 1ns/1ps
`include "port_link_defines.svh"
module port_link_config_flow_control_tb;
   logic ref_clk, sys_rst, hsel, hwrite, hready, hresp, irq, hreadyout;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   port_link_pkg::line_in_type  [`NUM_PORTS-1:0] li;
   port_link_pkg::line_out_type [`NUM_PORTS-1:0] lo;
   logic [11:0] ctl [`NUM_PORTS], kk [`NUM_PORTS];
   logic [8:0] mtx [`NUM_PORTS];
   logic [5:0] cfg [`NUM_PORTS], raw [`NUM_PORTS];
   logic [15:0] st [`NUM_PORTS];
   logic [7:0] um;
   logic [31:0] r;
   int errors, num_checks, p;

   assign hready = hreadyout;

   port_link_ctrl port_link_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
      .line_in(li), .line_out(lo));

   // one partner per port
   for (genvar g = 0; g < `NUM_PORTS; g++)
   begin : peer
      link_peer link_peer_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
         .ctl(ctl[g]), .mac_tx(mtx[g]), .lo(lo[g]), .li(li[g]));
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task final_report;
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // bounded wait for hready at a rising edge
   task hwait;
      int n;
      begin
         n = 0;
         @(posedge ref_clk);
         while (hready !== 1'b1)
         begin
            n++;
            if (n > 50)
            begin
               errors++;
               final_report;
            end
            @(posedge ref_clk);
         end
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hwait;
      htrans <= 2'h0;
      hwdata <= d;
      hwait;
      q = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
   endtask

   // expected status word from setting and partner
   function logic [15:0] expst(input logic [5:0] c, input logic [11:0] k);
      logic up, f;
      logic [1:0] sp;
      logic [4:0] cm;
      begin
         sp = k[8:7];
         f = 1'b0;
         cm = (c[2:0] == `MODE_1000F) ? `ABIL_1000F : `ABIL_ALL;
         cm = cm & k[6:2];
         if (c[2:0] == `MODE_AUTO || c[2:0] == `MODE_1000F)
         begin
            up = k[1] ? (cm != 5'h0) : (c[2:0] == `MODE_AUTO && sp != 2'h2);
            if (k[1])
            begin
               sp = cm[4] ? `SPD_1000 : (cm[3] | cm[2]) ? `SPD_100 : `SPD_10;
               f = cm[4] | cm[3] | (!cm[2] & cm[1]);
            end
         end
         else
         begin
            sp = (c[2:0] < `MODE_100F) ? `SPD_10 : `SPD_100;
            f = c[0];
            up = k[8:7] == sp;
         end
         up = up & k[0] & c[3];
         expst = {c[3] ? {up, 1'b0} : 2'h3, up & c[4], f, sp, up,
                  up & k[9] & (c[2:0] == `MODE_AUTO), 2'h0, c};
      end
   endfunction

   // one round of random settings, then status of every port
   task trial(input bit grp);
      logic [5:0] c;
      logic [15:0] e, m;
      begin
         for (p = 0; p < `NUM_PORTS; p++)
         begin
            if (!grp || p == 0)
            begin
               c = 6'($urandom);
               c[3] = ($urandom % 4) != 0;
            end
            raw[p] = c;
            cfg[p] = {c[5:3], (c[2:0] > `MODE_1000F) ? cfg[p][2:0] : c[2:0]};
            kk[p] = 12'($urandom);
            kk[p][0] = ($urandom % 8) != 0;
            kk[p][8:7] = 2'($urandom % 3);
            kk[p][11:10] = 2'h0;
            if (cfg[p][2:0] != `MODE_AUTO && cfg[p][2:0] != `MODE_1000F)
               kk[p][1] = 1'b0;
            ctl[p] <= kk[p];
         end
         if (grp)
            bus(1'b1, `OFS_SEL, 32'hFF, r);
         for (p = 0; p < (grp ? 1 : `NUM_PORTS); p++)
         begin
            if (!grp)
               bus(1'b1, `OFS_SEL, 32'(1 << p), r);
            bus(1'b1, `OFS_CFG, 32'(raw[p]), r);
            @(posedge ref_clk);
            #1;
            chk("restart", 32'(lo[p].link_up), 32'h0);
         end
         repeat (230) @(posedge ref_clk);
         for (p = 0; p < `NUM_PORTS; p++)
         begin
            bus(1'b0, `OFS_PSTAT + 8'(4 * p), 32'h0, r);
            e = expst(cfg[p], kk[p]);
            st[p] = e;
            m = e[9] ? 16'hFFFF : 16'hC2FF;
            chk("pstat", r & {16'hFFFF, m}, {16'h0, e & m});
            chk("link_up", 32'(lo[p].link_up), 32'(e[9]));
         end
      end
   endtask

   // buffer fill, receive carrier, then loopback and transmit
   task traffic;
      for (p = 0; p < `NUM_PORTS; p++)
         ctl[p][11:10] <= 2'h3;
      @(posedge ref_clk);
      #1;
      for (p = 0; p < `NUM_PORTS; p++)
         chk("pause", 32'(lo[p].pause_send), 32'(st[p][9] & st[p][12] & cfg[p][4]));
      @(posedge ref_clk);
      #1;
      for (p = 0; p < `NUM_PORTS; p++)
      begin
         chk("jam", 32'(lo[p].jam), 32'(st[p][9] & !st[p][12] & cfg[p][4]));
         chk("rx_line", 32'(lo[p].rx_valid), 32'(st[p][9] & !cfg[p][5]));
         // loopback never touches the line, so it may still send
         if (st[p][9] & !st[p][12])
            chk("tx_ready", 32'(lo[p].tx_ready), 32'(cfg[p][5]));
      end
      @(posedge ref_clk);
      for (p = 0; p < `NUM_PORTS; p++)
         ctl[p][11:10] <= 2'h0;
      @(posedge ref_clk);
      for (p = 0; p < `NUM_PORTS; p++)
         mtx[p] <= {1'b1, 8'($urandom)};
      @(posedge ref_clk);
      #1;
      for (p = 0; p < `NUM_PORTS; p++)
      begin
         chk("rx_valid", 32'(lo[p].rx_valid), 32'(cfg[p][3] & cfg[p][5]));
         if (cfg[p][3] & cfg[p][5])
            chk("rxd", 32'(lo[p].rxd), 32'(mtx[p][7:0]));
         if (!cfg[p][3] | cfg[p][5] | st[p][9])
            chk("tx_en", 32'(lo[p].tx_en), 32'(st[p][9] & !cfg[p][5]));
         chk("txd", 32'(lo[p].txd), 32'(mtx[p][7:0]));
      end
      @(posedge ref_clk);
      for (p = 0; p < `NUM_PORTS; p++)
         mtx[p] <= 9'h0;
   endtask

   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      errors++;
      final_report;
   end

   initial
   begin
      {sys_rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
      hsize = 3'h2;
      for (p = 0; p < `NUM_PORTS; p++)
      begin
         ctl[p] = 12'h0;
         mtx[p] = 9'h0;
         cfg[p] = 6'h08;
      end
      void'($urandom(48));
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (p = 0; p < `NUM_PORTS; p++)
      begin
         bus(1'b0, `OFS_PSTAT + 8'(4 * p), 32'h0, r);
         chk("pstat_rst", r, 32'h8);
      end
      bus(1'b1, `OFS_IRQ_EN, 32'h0, r);
      trial(1'b1);
      for (p = 0; p < `NUM_PORTS; p++)
         um[p] = st[p][9];
      bus(1'b0, `OFS_IRQ_STAT, 32'h0, r);
      chk("irq_stat", r, 32'(um));
      chk("irq_masked", 32'(irq), 32'h0);
      bus(1'b1, `OFS_IRQ_EN, 32'hFF, r);
      @(posedge ref_clk);
      #1;
      chk("irq", 32'(irq), 32'(|um));
      bus(1'b1, `OFS_IRQ_CLR, 32'hFF, r);
      @(posedge ref_clk);
      #1;
      chk("irq_clr", 32'(irq), 32'h0);
      bus(1'b0, `OFS_IRQ_STAT, 32'h0, r);
      chk("stat_clr", r, 32'h0);
      bus(1'b0, 8'h40, 32'h0, r);
      chk("unmapped", r, 32'h0);
      bus(1'b0, `OFS_CFG, 32'h0, r);
      chk("cfg_read", r, 32'h0);
      traffic;
      repeat (6)
      begin
         trial(1'($urandom));
         traffic;
      end
      final_report;
   end
endmodule // port_link_config_flow_control_tb

// ==== verilog/port_link_ctrl.sv ====
// per-port link setup, flow control and ahb-lite register slave
`timescale 1ns/1ps
`include "port_link_defines.svh"
// Functional notes
// - auto mode trades abilities with the peer and picks the best common.
// - a peer that does not negotiate gives sensed speed at half duplex.
// - forced mode uses the set speed/duplex; the peer must match it.
// - full duplex with flow control sends pause when buffers fill.
// - half duplex with flow control jams the sender as a collision.
// - gigabit on copper only comes up through negotiation.
// - after reset every port is auto with flow control off.
// - the speed/duplex setting takes only its six legal codes.
// - mac loopback returns transmit data to the receive path.
// - flow control off means no pause and no jam.
// - a disabled port carries nothing and shows link down.
// - crossover correction works only with auto speed and duplex.
// - status shows speed, duplex and flow control while up.
// - speed reads as 10, 100, 1000, or code 3 after parallel detect of sensed code 3, and duplex as full or half.
// - in half duplex the port holds transmit while receiving.
// - a config write applies identically to all selected ports.
module port_link_ctrl
(
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   // ahb-lite slave
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic [31:0]                       hrdata,
   // interrupt
   output logic                              irq,
   // line side, one bundle per port
   input  wire port_link_pkg::line_in_type  [`NUM_PORTS-1:0] line_in,
   output port_link_pkg::line_out_type      [`NUM_PORTS-1:0] line_out
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
      reg_hit = a[7:2] == ofs[7:2];
   endfunction
   // best common ability: {ok, speed, full}
   function automatic logic [3:0] resolve(input logic [4:0] c);
      if (c[4])
         resolve = {1'b1, `SPD_1000, 1'b1};
      else if (c[3])
         resolve = {1'b1, `SPD_100, 1'b1};
      else if (c[2])
         resolve = {1'b1, `SPD_100, 1'b0};
      else if (c[1])
         resolve = {1'b1, `SPD_10, 1'b1};
      else if (c[0])
         resolve = {1'b1, `SPD_10, 1'b0};
      else
         resolve = 4'h0;
   endfunction
   function automatic logic [1:0] mode_spd(input logic [2:0] m);
      mode_spd = (m == `MODE_100F || m == `MODE_100H) ? `SPD_100
                                                      : `SPD_10;
   endfunction
   function automatic logic mode_full(input logic [2:0] m);
      mode_full = m == `MODE_10F || m == `MODE_100F;
   endfunction
   function automatic logic [31:0] pstat(
      input port_link_pkg::port_state_type p);
      pstat = {16'h0000, p.ls, p.o.fc_on, p.o.full, p.o.speed,
               p.o.link_up, p.o.mdi_swap, 2'h0, p.lb, p.fc,
               p.en, p.mode};
   endfunction

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   port_link_pkg::state_type       s;
   port_link_pkg::state_type       next_s;
   port_link_pkg::port_state_type  ps;
   port_link_pkg::line_in_type     li;
   logic [3:0]                     r;
   logic                           up;
   logic                           half_busy;
   logic                           wr_cfg;
   logic [`NUM_PORTS-1:0]          apply_v;
   logic [`NUM_PORTS-1:0]          ev;
   logic [`NUM_PORTS-1:0]          clr;

   // next-state logic for bus, ports and interrupt
   always_comb
   begin
      next_s = s;
      ps = s.ports[0];
      li = line_in[0];
      r = 4'h0;
      up = 1'b0;
      half_busy = 1'b0;
      ev = '0;
      clr = '0;
      apply_v = '0;
      wr_cfg = s.wr_pend && reg_hit(s.wr_addr, `OFS_CFG);

      // address phase: capture writes, prepare read data
      next_s.wr_pend = 1'b0;
      if (hsel && htrans[1] && hready)
      begin
         next_s.wr_pend = hwrite;
         next_s.wr_addr = haddr[7:0];
         if (!hwrite)
         begin
            next_s.rdata = 32'h0000_0000;
            if (reg_hit(haddr[7:0], `OFS_SEL))
               next_s.rdata[7:0] = s.sel;
            else if (reg_hit(haddr[7:0], `OFS_IRQ_STAT))
               next_s.rdata[7:0] = s.irq_stat;
            else if (reg_hit(haddr[7:0], `OFS_IRQ_EN))
               next_s.rdata[7:0] = s.irq_en;
            else if (haddr[7:5] == `PSTAT_PAGE)
               next_s.rdata = pstat(s.ports[haddr[4:2]]);
         end
      end

      // data phase: register writes
      if (s.wr_pend)
      begin
         if (reg_hit(s.wr_addr, `OFS_SEL))
            next_s.sel = hwdata[7:0];
         if (reg_hit(s.wr_addr, `OFS_IRQ_EN))
            next_s.irq_en = hwdata[7:0];
         if (reg_hit(s.wr_addr, `OFS_IRQ_CLR))
            clr = hwdata[7:0];
      end

      // per-port link machine and line outputs
      for (int p = 0; p < `NUM_PORTS; p++)
      begin
         ps = s.ports[p];
         li = line_in[p];
         r = 4'h0;
         apply_v[p] = wr_cfg && s.sel[p];
         case (ps.ls)
            port_link_pkg::LS_OFF:
            begin
               if (ps.en)
                  ps.ls = port_link_pkg::LS_DOWN;
            end
            port_link_pkg::LS_DOWN:
            begin
               if (!ps.en)
                  ps.ls = port_link_pkg::LS_OFF;
               else if (li.sig_detect)
               begin
                  if (ps.mode == `MODE_AUTO || ps.mode == `MODE_1000F)
                  begin
                     if (li.peer_an)
                        r = resolve(li.peer_abil &
                                    ((ps.mode == `MODE_AUTO) ?
                                     `ABIL_ALL : `ABIL_1000F));
                     else if (ps.mode == `MODE_AUTO &&
                              li.sensed_spd != `SPD_1000)
                        r = {1'b1, li.sensed_spd, 1'b0};
                  end
                  else
                     r = {li.sensed_spd == mode_spd(ps.mode),
                          mode_spd(ps.mode), mode_full(ps.mode)};
                  if (r[3])
                  begin
                     ps.ls = port_link_pkg::LS_SETTLE;
                     ps.cnt = 8'h00;
                     ps.o.speed = r[2:1];
                     ps.o.full = r[0];
                     ps.o.mdi_swap = (ps.mode == `MODE_AUTO) &&
                                     li.crossed;
                  end
               end
            end
            port_link_pkg::LS_SETTLE:
            begin
               if (!ps.en)
                  ps.ls = port_link_pkg::LS_OFF;
               else if (!li.sig_detect)
                  ps.ls = port_link_pkg::LS_DOWN;
               else if (ps.cnt == 8'(`SETTLE_CYC - 1))
                  ps.ls = port_link_pkg::LS_UP;
               else
                  ps.cnt = ps.cnt + 8'h01;
            end
            port_link_pkg::LS_UP:
            begin
               if (!ps.en)
                  ps.ls = port_link_pkg::LS_OFF;
               else if (!li.sig_detect)
                  ps.ls = port_link_pkg::LS_DOWN;
            end
            default:
               ps.ls = port_link_pkg::LS_DOWN;
         endcase

         // config write to a selected port restarts its link
         if (apply_v[p])
         begin
            if (hwdata[`CFG_MODE_MSB:0] <= `MODE_1000F)
               ps.mode = hwdata[`CFG_MODE_MSB:0];
            ps.en = hwdata[`CFG_EN_BIT];
            ps.fc = hwdata[`CFG_FC_BIT];
            ps.lb = hwdata[`CFG_LB_BIT];
            ps.ls = port_link_pkg::LS_DOWN;
            ps.o.mdi_swap = 1'b0;
         end

         // line-side outputs from the next state
         up = ps.ls == port_link_pkg::LS_UP;
         half_busy = !ps.o.full && li.rx_busy;
         ev[p] = up != ps.o.link_up;
         ps.o.link_up = up;
         ps.o.fc_on = up && ps.fc;
         ps.o.pause_send = up && ps.o.full && ps.fc && li.buf_full &&
                           !ps.buf_q;
         ps.o.jam = up && half_busy && ps.fc && li.buf_full;
         ps.o.tx_ready = ps.en &&
                         (ps.lb || (up && !half_busy));
         ps.o.tx_en = ps.o.tx_ready && !ps.lb && li.tx_valid;
         ps.o.txd = li.txd;
         ps.o.rx_valid = ps.lb ? (ps.en && li.tx_valid)
                               : (up && li.rx_valid);
         ps.o.rxd = ps.lb ? li.txd : li.rxd;
         ps.buf_q = li.buf_full;
         next_s.ports[p] = ps;
      end

      // sticky link-change status, set wins over clear
      next_s.irq_stat = (s.irq_stat & ~clr) | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_en);

      // synchronous reset
      if (sys_rst)
      begin
         next_s = '0;
         for (int p = 0; p < `NUM_PORTS; p++)
         begin
            next_s.ports[p].mode = `RST_MODE;
            next_s.ports[p].en = `RST_EN;
            next_s.ports[p].fc = `RST_FC;
            next_s.ports[p].lb = `RST_LB;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk)
   begin
      s <= next_s;
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign hreadyout = 1'b1;        // zero wait state
   assign hresp = 1'b0;            // always okay
   assign hrdata = s.rdata;
   assign irq = s.irq;

   // -------------------------------------------------------------
   // per-port outputs and checks
   // -------------------------------------------------------------
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   generate
      for (genvar g = 0; g < `NUM_PORTS; g++)
      begin : gp
         assign line_out[g] = s.ports[g].o;

         // a quiet down state ready to resolve
         sequence down_ready;
            s.ports[g].ls == port_link_pkg::LS_DOWN && s.ports[g].en &&
            line_in[g].sig_detect && !apply_v[g];
         endsequence
         sequence restarted;
            s.ports[g].ls == port_link_pkg::LS_DOWN;
         endsequence

         an_resolve_a: assert property (
            down_ready ##0 (s.ports[g].mode == `MODE_AUTO &&
            line_in[g].peer_an && line_in[g].peer_abil[3] &&
            !line_in[g].peer_abil[4]) |=>
            s.ports[g].ls == port_link_pkg::LS_SETTLE &&
            s.ports[g].o.speed == `SPD_100 && s.ports[g].o.full)
            else $error("negotiation did not pick 100 full");

         parallel_half_a: assert property (
            down_ready ##0 (s.ports[g].mode == `MODE_AUTO &&
            !line_in[g].peer_an && line_in[g].sensed_spd == `SPD_10)
            |=> !s.ports[g].o.full && s.ports[g].o.speed == `SPD_10)
            else $error("parallel detect not half duplex");

         forced_match_a: assert property (
            down_ready ##0 (s.ports[g].mode == `MODE_100F &&
            line_in[g].sensed_spd != `SPD_100) |=> restarted)
            else $error("forced link formed on mismatch");

         pause_full_a: assert property (
            s.ports[g].o.pause_send |-> s.ports[g].o.full &&
            s.ports[g].o.fc_on && $past(line_in[g].buf_full))
            else $error("pause sent without cause");

         jam_half_a: assert property (
            s.ports[g].o.jam |-> !s.ports[g].o.full &&
            s.ports[g].o.fc_on && $past(line_in[g].rx_busy))
            else $error("jam outside half duplex");

         gig_neg_a: assert property (
            $rose(s.ports[g].ls == port_link_pkg::LS_SETTLE) &&
            s.ports[g].o.speed == `SPD_1000 |->
            $past(line_in[g].peer_an))
            else $error("gigabit without negotiation");

         reset_default_a: assert property (
            $past(sys_rst) |-> s.ports[g].mode == `MODE_AUTO &&
            !s.ports[g].fc)
            else $error("bad reset configuration");

         mode_legal_a: assert property (
            s.ports[g].mode <= `MODE_1000F)
            else $error("illegal speed setting held");

         loop_return_a: assert property (
            s.ports[g].lb && s.ports[g].en && line_in[g].tx_valid &&
            !apply_v[g] |=> s.ports[g].o.rx_valid &&
            s.ports[g].o.rxd == $past(line_in[g].txd) &&
            !s.ports[g].o.tx_en)
            else $error("loopback data not returned");

         off_quiet_a: assert property (
            !s.ports[g].en && !apply_v[g] |=> !s.ports[g].o.link_up
            && !s.ports[g].o.tx_en && !s.ports[g].o.rx_valid)
            else $error("disabled port active");

         xover_auto_a: assert property (
            s.ports[g].o.mdi_swap |-> s.ports[g].mode == `MODE_AUTO)
            else $error("crossover outside auto mode");

         status_up_a: assert property (
            s.ports[g].o.link_up |-> s.ports[g].ls ==
            port_link_pkg::LS_UP && s.ports[g].o.speed != 2'h3)
            else $error("status disagrees with link");

         half_order_a: assert property (
            s.ports[g].o.tx_en && !s.ports[g].o.full |->
            !$past(line_in[g].rx_busy))
            else $error("half duplex sent while receiving");

         range_apply_a: assert property (
            apply_v[g] && hwdata[2:0] <= `MODE_1000F |=>
            s.ports[g].mode == $past(hwdata[2:0]) &&
            s.ports[g].fc == $past(hwdata[`CFG_FC_BIT]))
            else $error("range write not applied");

         restart_a: assert property (
            apply_v[g] |=> restarted ##1
            s.ports[g].ls != port_link_pkg::LS_UP)
            else $error("link not restarted");
      end
   endgenerate

   irq_level_a: assert property (
      |(s.irq_stat & s.irq_en) |-> s.irq)
      else $error("interrupt not raised");

endmodule // port_link_ctrl
